// ### rtl/charge_optimizer.sv
// Purpose: adaptive charge level optimizer with apb register access
// Assumes: power stage reports charge done, active done and residual capacitor code
// Notes: one wait state on every apb access
//
// Notes on behaviour
// - each profile keeps its own learned target, apart from the fixed level.
// - profile zero charges to the fixed level; others adapt the target.
// - a profile starting optimization loads the capacitor maximum chosen by vcapmax.
// - on-demand cycle starts on command write or start pin; first charge of a nonzero profile is maximum.
// - when charging completes, an active cycle supplies the regulated output.
// - at active end the residual is compared with the selected margin threshold.
// - residual above margin lowers the target by one setting, holding at the lowest level.
// - residual below margin raises the target by one or two settings, up to the capacitor maximum.
// - far shortfall raises by two settings, a small shortfall by one.
// - residual equal to margin leaves the target unchanged.
// - each charge with nonzero profile goes to that profile's learned target.
// - profile initialization runs after power-on reset clears.
// - host selects profile and writes profile-reset; device reinitializes its target.
// - after reset margin is the highest code and profile one is selected.
// - a lighter load keeps lowering the target cycle by cycle until balanced.
// - slightly varying loads may toggle the target among neighbouring levels.
// - up to sixty-three learned profiles, chosen by a six-bit field.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module charge_optimizer
    import optimizer_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power stage
    input wire logic start_pin,
    input wire logic charge_done,
    input wire logic active_done,
    input wire logic [VCAP_W-1:0] vcap_residual,
    output logic charge_en,
    output logic [LEVEL_W-1:0] charge_level,
    output logic regulated_output_en,
    output logic [LEVEL_W-1:0] regulated_output_level
);

    // configuration registers
    logic [PROF_W-1:0] prof_reg, prof_next;
    logic [1:0] margin_reg, margin_next;
    logic [LEVEL_W-1:0] vfix_reg, vfix_next;
    logic [LEVEL_W-1:0] vset_reg, vset_next;
    logic vcapmax_reg, vcapmax_next;
    logic ecm_reg, ecm_next;
    logic eod_reg, eod_next;
    // apb answer
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    // optimizer state
    opt_state_t state_reg, state_next;
    logic [VCAP_W-1:0] resid_reg, resid_next;
    logic start_prev_reg;
    logic charge_en_reg, charge_en_next;
    logic [LEVEL_W-1:0] charge_level_reg, charge_level_next;
    logic reg_en_reg, reg_en_next;
    // store ports
    logic [LEVEL_W-1:0] target_level;
    logic target_valid;
    logic upd_en;
    logic [LEVEL_W-1:0] upd_level;
    logic rst_prof_en;
    logic rst_pending_reg;

    logic [IDX_W-1:0] idx;
    logic access;
    logic wr_stb;
    logic mapped;
    logic start_req;
    logic [LEVEL_W-1:0] cap_max;

    assign idx = paddr[11:2];
    assign access = psel && penable && pready_reg;
    assign wr_stb = access && pwrite;
    assign cap_max = cap_max_level(vcapmax_reg);

    always_comb begin
        case (idx)
            IDX_VCAP, IDX_PROF_MSB, IDX_COMMAND, IDX_SET1,
            IDX_SET4, IDX_SET5, IDX_OPT_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // learned levels live apart from the fixed level
    target_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .rd_prof(prof_reg),
        .cap_max(cap_max),
        .rd_level(target_level),
        .rd_valid(target_valid),
        .wr_en(upd_en),
        .wr_prof(prof_reg),
        .wr_level(upd_level),
        .clr_en(rst_pending_reg),
        .clr_prof(prof_reg)
    );

    // configuration and command writes
    always_comb begin
        prof_next = prof_reg;
        margin_next = margin_reg;
        vfix_next = vfix_reg;
        vset_next = vset_reg;
        vcapmax_next = vcapmax_reg;
        ecm_next = ecm_reg;
        eod_next = eod_reg;
        rst_prof_en = 1'b0;
        if (wr_stb) begin
            case (idx)
                IDX_PROF_MSB: prof_next[5:4] = pwdata[1:0];
                IDX_COMMAND: begin
                    prof_next[3:0] = pwdata[CMD_PROF_LSB +: 4];
                    ecm_next = pwdata[CMD_ECM_BIT];
                    eod_next = pwdata[CMD_EOD_BIT];
                    // self-clearing: restarts the profile named in this same write
                    rst_prof_en = pwdata[CMD_RSTPF_BIT];
                end
                IDX_SET1: begin
                    vfix_next = pwdata[SET1_VFIX_LSB +: LEVEL_W];
                    vset_next = pwdata[LEVEL_W-1:0];
                end
                IDX_SET4: vcapmax_next = pwdata[SET4_VCAPMAX_BIT];
                IDX_SET5: margin_next = pwdata[1:0];
                default: ;
            endcase
        end
    end

    // clear of the store uses the new profile when the write also changes it:
    // it waits one cycle, until the written profile stands in prof_reg

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prof_reg <= PROF_RESET;
            margin_reg <= MARGIN_RESET;
            vfix_reg <= VFIX_RESET;
            vset_reg <= VSET_RESET;
            vcapmax_reg <= VCAPMAX_RESET;
            ecm_reg <= 1'b0;
            eod_reg <= 1'b0;
        end else if (ce) begin
            prof_reg <= prof_next;
            margin_reg <= margin_next;
            vfix_reg <= vfix_next;
            vset_reg <= vset_next;
            vcapmax_reg <= vcapmax_next;
            ecm_reg <= ecm_next;
            eod_reg <= eod_next;
        end
    end

    // apb answer: ready one cycle after the first access cycle, read data captured with it
    always_comb begin
        pready_next = psel && penable && !pready_reg;
        pslverr_next = psel && penable && !pready_reg && !mapped;
        prdata_next = prdata_reg;
        if (psel && penable && !pready_reg) begin
            prdata_next = '0;
            if (!pwrite) begin
                case (idx)
                    IDX_VCAP: prdata_next[VCAP_W-1:0] = resid_reg;
                    IDX_PROF_MSB: prdata_next[1:0] = prof_reg[5:4];
                    IDX_COMMAND: begin
                        prdata_next[CMD_PROF_LSB +: 4] = prof_reg[3:0];
                        prdata_next[CMD_ACT_BIT] = state_reg != ST_STANDBY;
                        prdata_next[CMD_ECM_BIT] = ecm_reg;
                        prdata_next[CMD_EOD_BIT] = eod_reg;
                    end
                    IDX_SET1: prdata_next[7:0] = {vfix_reg, vset_reg};
                    IDX_SET4: prdata_next[SET4_VCAPMAX_BIT] = vcapmax_reg;
                    IDX_SET5: prdata_next[1:0] = margin_reg;
                    IDX_OPT_STATUS: begin
                        prdata_next[1:0] = state_reg;
                        prdata_next[STAT_LEVEL_LSB +: LEVEL_W] = target_level;
                        prdata_next[STAT_VALID_BIT] = target_valid;
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            rst_pending_reg <= 1'b0;
        end else if (ce) begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            rst_pending_reg <= rst_prof_en;
        end
    end

    // start pin is synchronous; only its rising edge counts
    assign start_req = (wr_stb && idx == IDX_COMMAND && pwdata[CMD_ACT_BIT]) ||
                       (start_pin && !start_prev_reg);

    // target update at the end of an active cycle
    always_comb begin
        logic [VCAP_W-1:0] thr;
        logic [VCAP_W:0] raised;
        thr = margin_level(margin_reg);
        raised = {2'b00, target_level};
        upd_level = target_level;
        if (resid_reg > thr) begin
            // repeats every cycle while the load stays lighter
            if (target_level > LEVEL_MIN) begin
                upd_level = target_level - 4'h1;
            end
        end else if (resid_reg < thr) begin
            if (thr - resid_reg >= FAR_SHORTFALL) begin
                raised = raised + 6'h02;
            end else begin
                raised = raised + 6'h01;
            end
            if (raised > {2'b00, cap_max}) begin
                upd_level = cap_max;
            end else begin
                upd_level = raised[LEVEL_W-1:0];
            end
        end
        upd_en = ce && state_reg == ST_EVAL && prof_reg != '0;
    end

    // optimizer sequence
    always_comb begin
        state_next = state_reg;
        resid_next = resid_reg;
        charge_en_next = 1'b0;
        charge_level_next = charge_level_reg;
        reg_en_next = 1'b0;
        case (state_reg)
            ST_STANDBY: begin
                // requests during a cycle are ignored, not queued
                if (start_req) begin
                    state_next = ST_CHARGE;
                    charge_en_next = 1'b1;
                    // unlearned nonzero profile reads as the maximum: first charge is full
                    charge_level_next = (prof_reg == '0) ? vfix_reg
                                                         : target_level;
                end
            end
            ST_CHARGE: begin
                charge_en_next = 1'b1;
                if (charge_done) begin
                    state_next = ST_ACTIVE;
                    charge_en_next = 1'b0;
                    reg_en_next = 1'b1;
                end
            end
            ST_ACTIVE: begin
                reg_en_next = 1'b1;
                if (active_done) begin
                    state_next = ST_EVAL;
                    reg_en_next = 1'b0;
                    resid_next = vcap_residual;
                end
            end
            ST_EVAL: state_next = ST_STANDBY;
            default: state_next = ST_STANDBY;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_STANDBY;
            resid_reg <= '0;
            start_prev_reg <= 1'b0;
            charge_en_reg <= 1'b0;
            charge_level_reg <= '0;
            reg_en_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            resid_reg <= resid_next;
            start_prev_reg <= start_pin;
            charge_en_reg <= charge_en_next;
            charge_level_reg <= charge_level_next;
            reg_en_reg <= reg_en_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign charge_en = charge_en_reg;
    assign charge_level = charge_level_reg;
    assign regulated_output_en = reg_en_reg;
    assign regulated_output_level = vset_reg;

endmodule : charge_optimizer
`default_nettype wire

// ### rtl/optimizer_pkg.sv
// Purpose: shared constants, types and helpers of the charge level optimizer
// Assumes: register indices are word indices on apb, byte address is index times four
// Notes: level codes are 4 bits, residual capacitor codes are 5 bits
package optimizer_pkg;

    localparam int unsigned PROF_W = 6;
    localparam int unsigned LEVEL_W = 4;
    localparam int unsigned VCAP_W = 5;
    localparam int unsigned NUM_PROF = 64;
    localparam int unsigned IDX_W = 10;

    // register word indices
    localparam logic [IDX_W-1:0] IDX_VCAP = 10'h005;
    localparam logic [IDX_W-1:0] IDX_PROF_MSB = 10'h007;
    localparam logic [IDX_W-1:0] IDX_COMMAND = 10'h008;
    localparam logic [IDX_W-1:0] IDX_SET1 = 10'h009;
    localparam logic [IDX_W-1:0] IDX_SET4 = 10'h00c;
    localparam logic [IDX_W-1:0] IDX_SET5 = 10'h00d;
    localparam logic [IDX_W-1:0] IDX_OPT_STATUS = 10'h010;

    // field positions
    localparam int unsigned CMD_PROF_LSB = 4;
    localparam int unsigned CMD_RSTPF_BIT = 3;
    localparam int unsigned CMD_ACT_BIT = 2;
    localparam int unsigned CMD_ECM_BIT = 1;
    localparam int unsigned CMD_EOD_BIT = 0;
    localparam int unsigned SET1_VFIX_LSB = 4;
    localparam int unsigned SET4_VCAPMAX_BIT = 4;
    localparam int unsigned STAT_LEVEL_LSB = 4;
    localparam int unsigned STAT_VALID_BIT = 8;

    // values after reset
    localparam logic [PROF_W-1:0] PROF_RESET = 6'h01;
    localparam logic [1:0] MARGIN_RESET = 2'h3;
    localparam logic [LEVEL_W-1:0] VFIX_RESET = 4'h0;
    localparam logic [LEVEL_W-1:0] VSET_RESET = 4'h0;
    localparam logic VCAPMAX_RESET = 1'b0;

    // level codes
    localparam logic [LEVEL_W-1:0] LEVEL_MIN = 4'h0;
    localparam logic [LEVEL_W-1:0] CAP_MAX_LO = 4'hb;
    localparam logic [LEVEL_W-1:0] CAP_MAX_HI = 4'hf;
    localparam logic [VCAP_W-1:0] MARGIN_BASE = 5'h01;
    localparam logic [VCAP_W-1:0] FAR_SHORTFALL = 5'h02;

    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_CHARGE,
        ST_ACTIVE,
        ST_EVAL
    } opt_state_t;

    function automatic logic [LEVEL_W-1:0] cap_max_level(input logic sel);
        cap_max_level = sel ? CAP_MAX_HI : CAP_MAX_LO;
    endfunction : cap_max_level

    function automatic logic [VCAP_W-1:0] margin_level(input logic [1:0] marg);
        margin_level = {3'h0, marg} + MARGIN_BASE;
    endfunction : margin_level

endpackage : optimizer_pkg

// ### rtl/target_store.sv
// Purpose: per-profile learned target levels with learned flags
// Assumes: one read port, one update port, one profile clear port
// Notes: an unlearned profile reads back as the capacitor maximum
`timescale 1ns/1ns
`default_nettype none
module target_store
    import optimizer_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // read side
    input wire logic [PROF_W-1:0] rd_prof,
    input wire logic [LEVEL_W-1:0] cap_max,
    output logic [LEVEL_W-1:0] rd_level,
    output logic rd_valid,
    // update side
    input wire logic wr_en,
    input wire logic [PROF_W-1:0] wr_prof,
    input wire logic [LEVEL_W-1:0] wr_level,
    // profile restart
    input wire logic clr_en,
    input wire logic [PROF_W-1:0] clr_prof
);

    logic [LEVEL_W-1:0] level_mem [NUM_PROF];
    logic [NUM_PROF-1:0] valid_reg;
    logic [NUM_PROF-1:0] valid_next;

    always_comb begin
        valid_next = valid_reg;
        if (clr_en) begin
            valid_next[clr_prof] = 1'b0;
        end
        // a learned update in the same cycle wins over the restart
        if (wr_en) begin
            valid_next[wr_prof] = 1'b1;
        end
    end

    // cleared flags at reset force every profile to re-learn from the maximum
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_reg <= '0;
        end else if (ce) begin
            valid_reg <= valid_next;
        end
    end

    always_ff @(posedge pclk) begin
        if (ce && wr_en) begin
            level_mem[wr_prof] <= wr_level;
        end
    end

    assign rd_valid = valid_reg[rd_prof];
    assign rd_level = rd_valid ? level_mem[rd_prof] : cap_max;

endmodule : target_store
`default_nettype wire

// ### tb/charge_optimizer_asserts.sv
// Purpose: port checker of charge_optimizer
// Assumes: ce held high
// Notes: standby is seen as both enables low after a non-active cycle
`timescale 1ns/1ns
`default_nettype none
module charge_optimizer_asserts
    import optimizer_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // power stage
    input wire logic start_pin,
    input wire logic charge_done,
    input wire logic active_done,
    input wire logic charge_en,
    input wire logic [LEVEL_W-1:0] charge_level,
    input wire logic regulated_output_en
);
    logic act_wr;
    logic idle;
    assign act_wr = psel && penable && pready && pwrite && paddr[11:2] == IDX_COMMAND
        && pwdata[CMD_ACT_BIT];
    assign idle = !charge_en && !regulated_output_en;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_wait;
        $rose(penable) && psel |-> !pready ##1 pready;
    endproperty
    a_wait: assert property (p_wait) else $error("apb wait state wrong");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_start;
        (act_wr || $rose(start_pin)) && idle && !$past(regulated_output_en) |=> charge_en;
    endproperty
    a_start: assert property (p_start) else $error("start ignored in standby");
    property p_cause;
        $rose(charge_en) |-> $past(act_wr) || ($past(start_pin) && !$past(start_pin, 2));
    endproperty
    a_cause: assert property (p_cause) else $error("charge without start");
    property p_hold;
        charge_en && !charge_done |=> charge_en && $stable(charge_level);
    endproperty
    a_hold: assert property (p_hold) else $error("charge dropped early");
    property p_active;
        charge_en && charge_done |=> !charge_en && regulated_output_en;
    endproperty
    a_active: assert property (p_active) else $error("no active after charge");
    property p_act_hold;
        regulated_output_en && !active_done |=> regulated_output_en;
    endproperty
    a_act_hold: assert property (p_act_hold) else $error("active dropped early");
    property p_eval;
        regulated_output_en && active_done |=> idle [*2];
    endproperty
    a_eval: assert property (p_eval) else $error("no eval gap");
endmodule : charge_optimizer_asserts
`default_nettype wire

// ### tb/power_stage_model.sv
// Purpose: behavioural power stage facing the optimizer
// Assumes: bench sets delay and residual before each start
// Notes: residual shows inverted data off its sample edge
`timescale 1ns/1ns
`default_nettype none
module power_stage_model
    import optimizer_pkg::*;
(
    // clock and optimizer side
    input wire logic pclk,
    input wire logic charge_en,
    input wire logic regulated_output_en,
    output logic charge_done,
    output logic active_done,
    output logic [VCAP_W-1:0] vcap_residual,
    // bench control
    input wire logic [3:0] dly,
    input wire logic [VCAP_W-1:0] resid
);
    logic [3:0] cnt;
    initial begin
        charge_done = 1'b0;
        active_done = 1'b0;
        cnt = 4'h0;
        vcap_residual = 5'h1f;
    end
    always @(posedge pclk) begin
        charge_done <= 1'b0;
        active_done <= 1'b0;
        vcap_residual <= ~resid;
        if ((charge_en && !charge_done) || (regulated_output_en && !active_done)) begin
            if (cnt >= dly) begin
                cnt <= 4'h0;
                charge_done <= charge_en;
                active_done <= regulated_output_en;
                vcap_residual <= resid;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : power_stage_model
`default_nettype wire

// ### tb/test_charge_optimizer.sv
// Purpose: self-checking bench of charge_optimizer
// Assumes: ce held high, apb master samples pready at the rising edge
// Notes: per-profile targets tracked in tgt
`timescale 1ns/1ns
`default_nettype none
module test_charge_optimizer import optimizer_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, start_pin, pready, pslverr, er;
    logic charge_done, active_done, charge_en, regulated_output_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [VCAP_W-1:0] vcap_residual, resid;
    logic [LEVEL_W-1:0] charge_level, regulated_output_level, mx, vf, vs;
    logic [LEVEL_W-1:0] tgt [NUM_PROF];
    logic [3:0] dly;
    logic [1:0] marg;
    int n_errors, samples_checked;

    charge_optimizer charge_optimizer_inst (.pclk, .presetn, .ce(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .start_pin, .charge_done,
        .active_done, .vcap_residual, .charge_en, .charge_level, .regulated_output_en,
        .regulated_output_level);
    power_stage_model power_stage_model_inst (.pclk, .charge_en, .regulated_output_en,
        .charge_done, .active_done, .vcap_residual, .dly, .resid);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // request held until pready is seen high at a rising edge, released on that edge
    task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) n_errors++;
    endtask : apb

    task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp,
                         input logic [31:0] m);
        apb(1'b0, idx, 32'h0);
        chk(rd & m, exp);
    endtask : rdchk

    task automatic wt(input logic act, input logic v);
        int n;
        n = 0;
        @(negedge pclk);
        while ((act ? regulated_output_en : charge_en) !== v && n < 100) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 100) n_errors++;
    endtask : wt

    function automatic logic [3:0] upd(input logic [3:0] t, input logic [4:0] r);
        int th;
        int v;
        th = int'(marg) + 1;
        v = int'(t);
        if (int'(r) > th) v = (v == 0) ? 0 : v - 1;
        else if (int'(r) < th) v = v + ((th - int'(r) >= 2) ? 2 : 1);
        if (v > int'(mx)) v = int'(mx);
        upd = 4'(v);
    endfunction : upd

    task automatic cyc(input logic [PROF_W-1:0] p, input logic [4:0] r, input logic pin);
        apb(1'b1, IDX_PROF_MSB, {30'h0, p[5:4]});
        apb(1'b1, IDX_COMMAND, {24'h0, p[3:0], 4'h0});
        resid <= r;
        dly <= 4'($urandom_range(0, 6));
        if (pin) begin
            @(posedge pclk);
            start_pin <= 1'b1;
            @(posedge pclk);
            start_pin <= 1'b0;
        end else begin
            apb(1'b1, IDX_COMMAND, {24'h0, p[3:0], 4'h4});
        end
        wt(1'b0, 1'b1);
        chk({28'h0, charge_level}, {28'h0, (p == 0) ? vf : tgt[p]});
        wt(1'b1, 1'b1);
        chk({28'h0, regulated_output_level}, {28'h0, vs});
        wt(1'b1, 1'b0);
        if (p != 0) begin
            tgt[p] = upd(tgt[p], r);
            rdchk(IDX_OPT_STATUS, {23'h1, tgt[p], 4'h0}, 32'h1f3);
        end
        rdchk(IDX_VCAP, {27'h0, r}, 32'h1f);
    endtask : cyc

    initial begin
        void'($urandom(56));
        {presetn, psel, penable, pwrite, start_pin} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {resid, dly, marg, mx, vf, vs} = {5'h00, 4'h0, 2'h3, CAP_MAX_LO, 8'h00};
        n_errors = 0;
        samples_checked = 0;
        foreach (tgt[i]) tgt[i] = CAP_MAX_HI;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(IDX_SET5, 32'h3, 32'h3);
        rdchk(IDX_COMMAND, 32'h10, 32'hff);
        rdchk(IDX_PROF_MSB, 32'h0, 32'h3);
        rdchk(IDX_OPT_STATUS, {23'h0, CAP_MAX_LO, 4'h0}, 32'h1f3);
        apb(1'b1, 10'h3ff, 32'hffff_ffff);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 10'h3ff, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, IDX_SET4, 32'h10);
        mx = CAP_MAX_HI;
        {vf, vs} = 8'($urandom);
        apb(1'b1, IDX_SET1, {24'h0, vf, vs});
        cyc(6'h00, 5'h1f, 1'b0);
        cyc(6'h01, 5'h05, 1'b1);
        cyc(6'h01, 5'h04, 1'b0);
        cyc(6'h01, 5'h03, 1'b1);
        cyc(6'h01, 5'h00, 1'b0);
        repeat (16) cyc(6'h3f, 5'h1f, 1'b0);
        cyc(6'h3f, 5'h02, 1'b1);
        for (int i = 0; i < 40; i++) begin
            if (i % 10 == 0) begin
                marg = 2'($urandom);
                apb(1'b1, IDX_SET5, {30'h0, marg});
            end
            cyc($urandom_range(0, 1) ? 6'h01 : 6'h2a, 5'($urandom_range(0, 10)), 1'($urandom));
        end
        apb(1'b1, IDX_PROF_MSB, 32'h0);
        apb(1'b1, IDX_COMMAND, 32'h18);
        tgt[1] = mx;
        rdchk(IDX_OPT_STATUS, {23'h0, mx, 4'h0}, 32'h1f3);
        cyc(6'h01, 5'h05, 1'b0);
        // mid-run reset: learned flags and configuration must start over
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(IDX_OPT_STATUS, {23'h0, CAP_MAX_LO, 4'h0}, 32'h1f3);
        rdchk(IDX_SET5, 32'h3, 32'h3);
        end_sim();
    end

    initial begin
        #400000;
        n_errors++;
        end_sim();
    end
endmodule : test_charge_optimizer
bind charge_optimizer charge_optimizer_asserts charge_optimizer_asserts_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .start_pin,
    .charge_done, .active_done, .charge_en, .charge_level, .regulated_output_en);
`default_nettype wire
